// ---- rtl/pma_pkg.sv ----
// Shared constants and types for the macrocell array
package pma_pkg;
  // ==========================================================
  // Array geometry
  localparam int CELLS = 16;
  localparam int GRP = 8;
  localparam logic [3:0] NATIVE_ONE = 4'h7;
  localparam logic [3:0] NATIVE_TWO = 4'hF;
  localparam logic [3:0] CAP_ONE = 4'h6;
  localparam logic [3:0] CAP_TWO_LO = 4'h5;
  localparam logic [3:0] CAP_TWO_HI = 4'h6;
  // ==========================================================
  // Register offsets inside the configuration block window
  localparam logic [7:0] OFS_IN_A = 8'h00;
  localparam logic [7:0] OFS_IN_B = 8'h01;
  localparam logic [7:0] OFS_IN_C = 8'h02;
  localparam logic [7:0] OFS_CELL_ONE = 8'h10;
  localparam logic [7:0] OFS_CELL_TWO = 8'h11;
  localparam logic [7:0] OFS_MASK_ONE = 8'h12;
  localparam logic [7:0] OFS_MASK_TWO = 8'h13;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // ==========================================================
  // Modes
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} pma_ff_type;
  typedef enum logic [1:0] {IN_PASS, IN_LATCH, IN_REG} pma_imc_type;
endpackage : pma_pkg

// ---- rtl/pma_output_cell.sv ----
// One output cell: polarity stage, configurable flip-flop, output select
`timescale 1ns/1ps
`default_nettype none
module pma_output_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic term_sum,
  input wire logic polarity,
  input wire logic comb_sel,
  input wire logic clk_sel,
  input wire logic [1:0] ff_kind,
  input wire logic ded_rise,
  input wire logic pt_clk,
  input wire logic pt_preset,
  input wire logic [1:0] pt_clr,
  input wire logic pt_k,
  input wire logic load_en,
  input wire logic load_bit,
  output logic cell_value,
  output logic ff_state
);
  logic state_q;
  logic pt_clk_q;
  logic data_in;
  logic tick;
  pma_pkg::pma_ff_type kind;

  assign data_in = term_sum ^ polarity;
  assign kind = pma_pkg::pma_ff_type'(ff_kind);
  assign tick = clk_sel ? ded_rise : (pt_clk & ~pt_clk_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pt_clk_q <= 1'b0;
    end else begin
      pt_clk_q <= pt_clk;
    end
  end

  // Host load sits above clear, preset and clock so software always wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= 1'b0;
    end else if (load_en) begin
      state_q <= load_bit;
    end else if (|pt_clr) begin
      state_q <= 1'b0;
    end else if (pt_preset) begin
      state_q <= 1'b1;
    end else if (tick) begin
      case (kind)
        pma_pkg::FF_D: state_q <= data_in;
        pma_pkg::FF_T: state_q <= state_q ^ data_in;
        pma_pkg::FF_JK: state_q <= (data_in & ~state_q) | (~pt_k & state_q);
        pma_pkg::FF_SR: state_q <= data_in | (~pt_k & state_q);
        default: state_q <= state_q;
      endcase
    end
  end

  assign cell_value = comb_sel ? data_in : state_q;
  assign ff_state = state_q;

  load_priority_a: assert property (@(posedge clk) disable iff (!rst_n)
    load_en |=> state_q == $past(load_bit)) else $error("host load lost");
  clear_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!load_en && |pt_clr) |=> !state_q) else $error("clear ignored");
endmodule : pma_output_cell
`default_nettype wire

// ---- rtl/pma_input_port.sv ----
// Eight input cells of one port: pass, transparent latch or edge register
`timescale 1ns/1ps
`default_nettype none
module pma_input_port #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  input wire logic [WIDTH-1:0][1:0] mode,
  input wire logic [1:0] src_ale,
  input wire logic pt_lo,
  input wire logic pt_hi,
  input wire logic ale,
  output logic [WIDTH-1:0] value_q
);
  logic [1:0] en;
  logic [1:0] en_q;

  if (WIDTH != 8) begin : g_bad_width
    $error("input port must be eight cells wide");
  end

  assign en[0] = src_ale[0] ? ale : pt_lo;
  assign en[1] = src_ale[1] ? ale : pt_hi;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 2'h0;
    end else begin
      en_q <= en;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        case (pma_pkg::pma_imc_type'(mode[i]))
          pma_pkg::IN_PASS: value_q[i] <= pin[i];
          pma_pkg::IN_LATCH: if (en[i/4]) value_q[i] <= pin[i];
          pma_pkg::IN_REG: if (en[i/4] && !en_q[i/4]) value_q[i] <= pin[i];
          default: value_q[i] <= value_q[i];
        endcase
      end
    end
  end

  input_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode[0] == 2'h0) |=> value_q[0] == $past(pin[0])) else $error("pass cell stale");
endmodule : pma_input_port
`default_nettype wire

// ---- rtl/pma_macrocell_array.sv ----
// Macrocell array: sixteen output cells, 24 input cells, host load and read
// Operation
// - Sixteen output cells, two routable groups
// - Host loads and reads cells, bit n
// - Native and borrowable term counts per group
// - A used term is never shared
// - XOR stage sets output polarity
// - Select flop or combinational, feed back
// - Flop acts as D, T, JK, SR
// - Flop clock: product term or dedicated pin
// - Active high preset, two-term clear
// - Host load overrides preset, clear, clock
// - Edge or level loading on write strobe
// - Mask bit one blocks writes, reset zero
// - Pin enable is term OR direction
// - No enable equation means always enabled
// - Internal node frees pin, keeps feedback
// - 24 input cells: latch, register, pass
// - Input enable per nibble: term or strobe
// - Host reads present input cell values
// - Strobe-clocked input cells capture high address
// - Array sits at configuration block address
`timescale 1ns/1ps
`default_nettype none
module pma_macrocell_array #(
  parameter int GROUP_CELLS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic config_block_select,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_data_in,
  input wire logic bus_control_zero_n,
  input wire logic bus_control_one_n,
  input wire logic address_latch_strobe,
  input wire logic dedicated_clock_pin,
  input wire logic [15:0][3:0] pt_native,
  input wire logic [15:0] pt_clk,
  input wire logic [15:0] pt_preset,
  input wire logic [15:0][1:0] pt_clr,
  input wire logic [15:0] pt_k,
  input wire logic [15:0] pt_oe,
  input wire logic [5:0] pt_in_enable,
  input wire logic [15:0][3:0] cfg_use_native,
  input wire logic [15:0][7:0] cfg_borrow,
  input wire logic [15:0] cfg_polarity,
  input wire logic [15:0] cfg_comb_sel,
  input wire logic [15:0] cfg_clk_pin,
  input wire logic [15:0][1:0] cfg_ff_kind,
  input wire logic [15:0] cfg_node,
  input wire logic [15:0] cfg_has_oe_eq,
  input wire logic [7:0] cfg_route_one,
  input wire logic [7:0] cfg_route_two,
  input wire logic cfg_level_load,
  input wire logic [7:0][1:0] cfg_in_mode_a,
  input wire logic [7:0][1:0] cfg_in_mode_b,
  input wire logic [7:0][1:0] cfg_in_mode_c,
  input wire logic [5:0] cfg_in_ale,
  input wire logic [7:0] dir_a,
  input wire logic [7:0] dir_b,
  input wire logic [7:0] dir_c,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  output logic [15:0] feedback_q,
  output logic [7:0] input_bus_a,
  output logic [7:0] input_bus_b,
  output logic [7:0] input_bus_c
);
  // ==========================================================
  // Helpers
  function automatic int nb(input int c, input int d);
    return (c & ~7) | ((c + d) & 7);
  endfunction : nb

  function automatic logic [3:0] native_mask(input int c);
    return (c < 8) ? pma_pkg::NATIVE_ONE : pma_pkg::NATIVE_TWO;
  endfunction : native_mask

  function automatic logic [3:0] cap_of(input int c);
    if (c < 8) return pma_pkg::CAP_ONE;
    return (c < 12) ? pma_pkg::CAP_TWO_LO : pma_pkg::CAP_TWO_HI;
  endfunction : cap_of

  // Keeps the lowest requested terms, at most cap of them
  function automatic logic [7:0] limit_req(input logic [7:0] m, input logic [3:0] cap);
    logic [7:0] r;
    logic [3:0] n;
    r = 8'h00;
    n = 4'h0;
    for (int b = 0; b < 8; b++) begin
      if (m[b] && n < cap) begin
        r[b] = 1'b1;
        n = n + 4'h1;
      end
    end
    return r;
  endfunction : limit_req

  if (GROUP_CELLS != pma_pkg::GRP) begin : g_bad_group
    $error("each group holds exactly eight cells");
  end

  // ==========================================================
  // Product term allocation
  logic [15:0][3:0] use_nat;
  logic [15:0][3:0] req_l;
  logic [15:0][3:0] req_r;
  logic [15:0][3:0] gnt_l;
  logic [15:0][3:0] gnt_r;
  logic [15:0] term_sum;

  // A cell borrows from its two neighbours in the group; a term reserved by
  // its owner or by the cell borrowing rightward is denied to everyone else
  always_comb begin
    for (int c = 0; c < 16; c++) begin
      use_nat[c] = cfg_use_native[c] & native_mask(c);
      {req_r[c], req_l[c]} = limit_req(cfg_borrow[c]
        & {native_mask(nb(c, 1)), native_mask(nb(c, 7))}, cap_of(c));
    end
    for (int c = 0; c < 16; c++) begin
      gnt_r[c] = req_r[c] & ~use_nat[nb(c, 1)];
      gnt_l[c] = req_l[c] & ~use_nat[nb(c, 7)] & ~req_r[nb(c, 6)];
      term_sum[c] = |(pt_native[c] & use_nat[c])
        | |(pt_native[nb(c, 1)] & gnt_r[c])
        | |(pt_native[nb(c, 7)] & gnt_l[c]);
    end
  end

  // ==========================================================
  // Host write path
  logic wr_act;
  logic wr_act_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic fire;
  logic [7:0] f_addr;
  logic [7:0] f_data;
  logic [7:0] mask_one_q;
  logic [7:0] mask_two_q;
  logic [7:0] load_one;
  logic [7:0] load_two;

  assign wr_act = ~bus_control_zero_n & config_block_select;

  // Address and data are held while the strobe is low, since both may be
  // gone by the time the trailing edge is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        wr_addr_q <= host_addr;
        wr_data_q <= host_data_in;
      end
    end
  end

  assign fire = cfg_level_load ? wr_act : (wr_act_q & ~wr_act);
  assign f_addr = cfg_level_load ? host_addr : wr_addr_q;
  assign f_data = cfg_level_load ? host_data_in : wr_data_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_one_q <= pma_pkg::MASK_RST;
      mask_two_q <= pma_pkg::MASK_RST;
    end else if (fire) begin
      if (f_addr == pma_pkg::OFS_MASK_ONE) mask_one_q <= f_data;
      if (f_addr == pma_pkg::OFS_MASK_TWO) mask_two_q <= f_data;
    end
  end

  assign load_one = (fire && f_addr == pma_pkg::OFS_CELL_ONE) ? ~mask_one_q : 8'h00;
  assign load_two = (fire && f_addr == pma_pkg::OFS_CELL_TWO) ? ~mask_two_q : 8'h00;

  // ==========================================================
  // Output cells
  logic ded_q;
  logic ded_rise;
  logic [15:0] load_vec;
  logic [15:0] cell_value;
  logic [15:0] ff_state;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ded_q <= 1'b0;
    end else begin
      ded_q <= dedicated_clock_pin;
    end
  end

  assign ded_rise = dedicated_clock_pin & ~ded_q;
  assign load_vec = {load_two, load_one};

  for (genvar g = 0; g < 16; g++) begin : g_cell
    pma_output_cell u_cell (
      .clk(clk),
      .rst_n(rst_n),
      .term_sum(term_sum[g]),
      .polarity(cfg_polarity[g]),
      .comb_sel(cfg_comb_sel[g]),
      .clk_sel(cfg_clk_pin[g]),
      .ff_kind(cfg_ff_kind[g]),
      .ded_rise(ded_rise),
      .pt_clk(pt_clk[g]),
      .pt_preset(pt_preset[g]),
      .pt_clr(pt_clr[g]),
      .pt_k(pt_k[g]),
      .load_en(load_vec[g]),
      .load_bit(f_data[g % 8]),
      .cell_value(cell_value[g]),
      .ff_state(ff_state[g])
    );
  end

  // ==========================================================
  // Pin routing and drivers
  logic [7:0] drive_a;
  logic [7:0] drive_b1;
  logic [7:0] drive_b2;
  logic [7:0] drive_c;
  logic [15:0] en_cell;

  // Port B bit n is shared; group one takes it when both groups ask
  assign drive_a = ~cfg_node[7:0] & ~cfg_route_one;
  assign drive_b1 = ~cfg_node[7:0] & cfg_route_one;
  assign drive_b2 = ~cfg_node[15:8] & ~cfg_route_two & ~drive_b1;
  assign drive_c = ~cfg_node[15:8] & cfg_route_two;
  assign en_cell = pt_oe | ~cfg_has_oe_eq;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_out <= 8'h00;
      port_b_out <= 8'h00;
      port_c_out <= 8'h00;
    end else begin
      port_a_out <= cell_value[7:0];
      port_b_out <= (drive_b1 & cell_value[7:0]) | (~drive_b1 & cell_value[15:8]);
      port_c_out <= cell_value[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_oe <= 8'h00;
      port_b_oe <= 8'h00;
      port_c_oe <= 8'h00;
    end else begin
      port_a_oe <= drive_a & (en_cell[7:0] | dir_a);
      port_b_oe <= (drive_b1 & (en_cell[7:0] | dir_b))
        | (drive_b2 & (en_cell[15:8] | dir_b));
      port_c_oe <= drive_c & (en_cell[15:8] | dir_c);
    end
  end

  // Feedback runs whether or not the cell owns a pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feedback_q <= 16'h0000;
    end else begin
      feedback_q <= cell_value;
    end
  end

  // ==========================================================
  // Input cells
  pma_input_port #(.WIDTH(8)) u_in_a (
    .clk(clk),
    .rst_n(rst_n),
    .pin(port_a_in),
    .mode(cfg_in_mode_a),
    .src_ale(cfg_in_ale[1:0]),
    .pt_lo(pt_in_enable[0]),
    .pt_hi(pt_in_enable[1]),
    .ale(address_latch_strobe),
    .value_q(input_bus_a)
  );

  pma_input_port #(.WIDTH(8)) u_in_b (
    .clk(clk),
    .rst_n(rst_n),
    .pin(port_b_in),
    .mode(cfg_in_mode_b),
    .src_ale(cfg_in_ale[3:2]),
    .pt_lo(pt_in_enable[2]),
    .pt_hi(pt_in_enable[3]),
    .ale(address_latch_strobe),
    .value_q(input_bus_b)
  );

  pma_input_port #(.WIDTH(8)) u_in_c (
    .clk(clk),
    .rst_n(rst_n),
    .pin(port_c_in),
    .mode(cfg_in_mode_c),
    .src_ale(cfg_in_ale[5:4]),
    .pt_lo(pt_in_enable[4]),
    .pt_hi(pt_in_enable[5]),
    .ale(address_latch_strobe),
    .value_q(input_bus_c)
  );

  // ==========================================================
  // Host read path
  logic rd_act;

  assign rd_act = ~bus_control_one_n & config_block_select;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_out <= pma_pkg::READ_IDLE;
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= rd_act;
      case (host_addr)
        pma_pkg::OFS_IN_A: host_data_out <= input_bus_a;
        pma_pkg::OFS_IN_B: host_data_out <= input_bus_b;
        pma_pkg::OFS_IN_C: host_data_out <= input_bus_c;
        pma_pkg::OFS_CELL_ONE: host_data_out <= ff_state[7:0];
        pma_pkg::OFS_CELL_TWO: host_data_out <= ff_state[15:8];
        pma_pkg::OFS_MASK_ONE: host_data_out <= mask_one_q;
        pma_pkg::OFS_MASK_TWO: host_data_out <= mask_two_q;
        default: host_data_out <= pma_pkg::READ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  mask_blocks_a: assert property ((load_one & mask_one_q) == 8'h00
    && (load_two & mask_two_q) == 8'h00) else $error("masked cell loaded");
  edge_load_a: assert property ((!cfg_level_load && wr_act_q && !wr_act
    && wr_addr_q == pma_pkg::OFS_CELL_ONE && mask_one_q == 8'h00)
    |=> ff_state[7:0] == $past(wr_data_q)) else $error("edge load missed");
  level_load_a: assert property ((cfg_level_load && wr_act
    && host_addr == pma_pkg::OFS_CELL_TWO && mask_two_q == 8'h00)
    |=> ff_state[15:8] == $past(host_data_in)) else $error("level load missed");
  idle_bus_a: assert property (!fire |=> $stable(mask_one_q) && $stable(mask_two_q))
    else $error("mask changed without write");
  read_back_a: assert property ((rd_act && host_addr == pma_pkg::OFS_CELL_ONE)
    |=> host_data_oe && host_data_out == $past(ff_state[7:0]))
    else $error("cell read wrong");
  oe_default_a: assert property ((drive_a[0] && !cfg_has_oe_eq[0]) |=> port_a_oe[0])
    else $error("pin not enabled");
  node_free_a: assert property (cfg_node[0] |=> !port_a_oe[0]
    ##0 feedback_q[0] == $past(cell_value[0])) else $error("node drove pin");
  term_unique_a: assert property ((gnt_r[0] & use_nat[1]) == 4'h0
    && (gnt_l[2] & gnt_r[0]) == 4'h0) else $error("term shared");
  borrow_cap_a: assert property ($countones({gnt_r[8], gnt_l[8]}) <= 5)
    else $error("borrow over limit");

  edge_write_c: cover property (!cfg_level_load && wr_act ##1 !wr_act);
  level_write_c: cover property (cfg_level_load && |load_two);
  borrow_c: cover property (|gnt_r[9] && |gnt_l[9]);
endmodule : pma_macrocell_array
`default_nettype wire

// ---- tb/pma_host_model.sv ----
// Host bus master model for the macrocell array register window
`timescale 1ns/1ps
`default_nettype none
module pma_host_model (
  input wire logic clk,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  output logic config_block_select,
  output logic [7:0] host_addr,
  output logic [7:0] host_data_in,
  output logic bus_control_zero_n,
  output logic bus_control_one_n,
  output logic address_latch_strobe
);
  initial begin
    config_block_select = 1'b0;
    host_addr = 8'h00;
    host_data_in = 8'h00;
    bus_control_zero_n = 1'b1;
    bus_control_one_n = 1'b1;
    address_latch_strobe = 1'b0;
  end
  // ==========================================================
  // Bus cycles
  // Released address and data lines show the inverse of their last value, so stale data never matches
  task automatic release_bus();
    config_block_select = 1'b0;
    bus_control_zero_n = 1'b1;
    bus_control_one_n = 1'b1;
    host_addr = ~host_addr;
    host_data_in = ~host_data_in;
  endtask : release_bus
  task automatic write(input logic [7:0] addr, input logic [7:0] data, input logic sel);
    @(posedge clk);
    #1;
    config_block_select = sel;
    host_addr = addr;
    host_data_in = data;
    bus_control_zero_n = 1'b0;
    @(posedge clk);
    #1;
    release_bus();
    // Strobe stays high a full cycle so edge loading sees each write
    @(posedge clk);
    #1;
  endtask : write
  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic oe);
    @(posedge clk);
    #1;
    config_block_select = 1'b1;
    host_addr = addr;
    bus_control_one_n = 1'b0;
    @(posedge clk);
    @(posedge clk);
    data = host_data_out;
    oe = host_data_oe;
    #1;
    release_bus();
  endtask : read
  task automatic strobe();
    @(posedge clk);
    #1;
    address_latch_strobe = 1'b1;
    @(posedge clk);
    #1;
    address_latch_strobe = 1'b0;
  endtask : strobe
endmodule : pma_host_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the macrocell array
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam logic [7:0] C1 = pma_pkg::OFS_CELL_ONE;
  localparam logic [7:0] C2 = pma_pkg::OFS_CELL_TWO;
  localparam logic [7:0] M1 = pma_pkg::OFS_MASK_ONE;
  localparam logic [7:0] M2 = pma_pkg::OFS_MASK_TWO;
  logic clk, rst_n, config_block_select, bus_control_zero_n, bus_control_one_n;
  logic address_latch_strobe, dedicated_clock_pin, cfg_level_load, host_data_oe, oe;
  logic [7:0] host_addr, host_data_in, host_data_out, cfg_route_one, cfg_route_two;
  logic [7:0] dir_a, dir_b, dir_c, port_a_in, port_b_in, port_c_in, rd, d1, d2, dv;
  logic [7:0] port_a_out, port_a_oe, port_b_out, port_b_oe, port_c_out, port_c_oe;
  logic [7:0] input_bus_a, input_bus_b, input_bus_c;
  logic [15:0] pt_clk, pt_preset, pt_k, pt_oe, cfg_polarity, cfg_comb_sel, cfg_clk_pin;
  logic [15:0] cfg_node, cfg_has_oe_eq, feedback_q;
  logic [15:0][3:0] pt_native, cfg_use_native;
  logic [15:0][1:0] pt_clr, cfg_ff_kind;
  logic [15:0][7:0] cfg_borrow;
  logic [7:0][1:0] cfg_in_mode_a, cfg_in_mode_b, cfg_in_mode_c;
  logic [5:0] pt_in_enable, cfg_in_ale;
  int num_errors = 0;
  int compares = 0;
  integer seed = 32'hf53c55bf;
  pma_macrocell_array #(.GROUP_CELLS(8)) u_dut (.clk, .rst_n, .config_block_select,
    .host_addr, .host_data_in, .bus_control_zero_n, .bus_control_one_n,
    .address_latch_strobe, .dedicated_clock_pin, .pt_native, .pt_clk, .pt_preset, .pt_clr,
    .pt_k, .pt_oe, .pt_in_enable, .cfg_use_native, .cfg_borrow, .cfg_polarity, .cfg_comb_sel,
    .cfg_clk_pin, .cfg_ff_kind, .cfg_node, .cfg_has_oe_eq, .cfg_route_one, .cfg_route_two,
    .cfg_level_load, .cfg_in_mode_a, .cfg_in_mode_b, .cfg_in_mode_c, .cfg_in_ale, .dir_a,
    .dir_b, .dir_c, .port_a_in, .port_b_in, .port_c_in, .host_data_out, .host_data_oe,
    .port_a_out, .port_a_oe, .port_b_out, .port_b_oe, .port_c_out, .port_c_oe, .feedback_q,
    .input_bus_a, .input_bus_b, .input_bus_c);
  pma_host_model u_host (.clk, .host_data_out, .host_data_oe, .config_block_select,
    .host_addr, .host_data_in, .bus_control_zero_n, .bus_control_one_n,
    .address_latch_strobe);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [7:0] masked(logic [7:0] old, logic [7:0] nw, logic [7:0] m);
    return (old & m) | (nw & ~m);
  endfunction : masked
  function automatic logic ff_next(int kind, logic q, logic j, logic k);
    case (kind)
      0: return j;
      1: return q ^ j;
      2: return (j & ~q) | (~k & q);
      default: return j | (q & ~k);
    endcase
  endfunction : ff_next
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write(a, d, 1'b1);
  endtask : wr
  task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
    u_host.read(a, rd, oe);
    `CHK(rd, e)
  endtask : chkrd
  task automatic conclude();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    #(4000 * 25);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
  // ==========================================================
  // Scenarios
  initial begin
    {pt_native, cfg_use_native, pt_clk, pt_preset, pt_k, pt_oe, pt_clr, cfg_ff_kind} = '0;
    {cfg_borrow, cfg_polarity, cfg_comb_sel, cfg_clk_pin, cfg_node, cfg_has_oe_eq} = '0;
    {cfg_in_mode_a, cfg_in_mode_b, cfg_in_mode_c, pt_in_enable, cfg_in_ale} = '0;
    {dir_a, dir_b, dir_c, cfg_route_one, cfg_level_load, dedicated_clock_pin} = '0;
    {port_a_in, port_b_in, port_c_in} = $random(seed);
    cfg_route_two = 8'hFF;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chkrd(M1, pma_pkg::MASK_RST);
    chkrd(M2, pma_pkg::MASK_RST);
    chkrd(C1, 8'h00);
    `CHK(oe, 1'b1)
    `CHK(port_a_oe, 8'hFF)
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      d1 = $random(seed);
      d2 = $random(seed);
      wr(C1, d1);
      wr(C2, d2);
      chkrd(C1, d1);
      chkrd(C2, d2);
      `CHK(port_a_out, d1)
      `CHK(port_c_out, d2)
    end
    $display("edge load test done");
    dv = $random(seed);
    wr(M1, 8'h0F);
    chkrd(M1, 8'h0F);
    wr(C1, dv);
    chkrd(C1, masked(d1, dv, 8'h0F));
    wr(M2, 8'hA5);
    chkrd(M2, 8'hA5);
    wr(M2, 8'h00);
    wr(M1, 8'h00);
    wr(8'h20, 8'h5A);
    chkrd(8'h20, pma_pkg::READ_IDLE);
    u_host.write(C1, ~dv, 1'b0);
    chkrd(C1, masked(d1, dv, 8'h0F));
    cfg_level_load = 1'b1;
    d2 = $random(seed);
    wr(C2, d2);
    chkrd(C2, d2);
    cfg_level_load = 1'b0;
    $display("mask and level test done");
    cfg_comb_sel[0] = 1'b1;
    cfg_use_native[1:0] = 8'h11;
    for (int i = 0; i < 4; i++) begin
      pt_native[0][0] = i[0];
      cfg_polarity[0] = i[1];
      settle();
      `CHK(feedback_q[0], i[0] ^ i[1])
      `CHK(port_a_out[0], i[0] ^ i[1])
    end
    // Cell 9 asks for all eight neighbour terms; only five fit its cap
    cfg_comb_sel[9] = 1'b1;
    cfg_borrow[9] = 8'hFF;
    for (int i = 0; i < 2; i++) begin
      pt_native[10] = 4'h1 << i;
      settle();
      `CHK(feedback_q[9], i == 0)
    end
    {pt_native[10], cfg_use_native[10]} = 8'h11;
    settle();
    `CHK(feedback_q[9], 1'b0)
    {cfg_comb_sel[9], cfg_borrow[9], pt_native[10], cfg_use_native[10]} = '0;
    wr(C1, 8'h00);
    cfg_clk_pin[1] = 1'b1;
    pt_native[1][0] = 1'b1;
    settle();
    `CHK(feedback_q[1], 1'b0)
    dedicated_clock_pin = 1'b1;
    settle();
    `CHK(feedback_q[1], 1'b1)
    {dedicated_clock_pin, cfg_clk_pin[1]} = 2'b00;
    cfg_use_native[2] = 4'h1;
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 3; c++) begin
        cfg_ff_kind[2] = k[1:0];
        pt_native[2][0] = (c == 1);
        pt_k[2] = (c == 0);
        wr(C1, 8'h04);
        pt_clk[2] = 1'b1;
        settle();
        pt_clk[2] = 1'b0;
        u_host.read(C1, rd, oe);
        `CHK(rd[2], ff_next(k, 1'b1, c == 1, c == 0))
      end
    end
    wr(C1, 8'h00);
    pt_preset[7:0] = 8'hFF;
    settle();
    pt_preset[7:0] = 8'h00;
    chkrd(C1, 8'hFF);
    pt_clr[3] = 2'b10;
    settle();
    pt_clr[3] = 2'b00;
    chkrd(C1, 8'hF7);
    $display("flip-flop test done");
    cfg_has_oe_eq[7:0] = 8'hFF;
    for (int i = 0; i < 3; i++) begin
      d1 = $random(seed);
      dv = $random(seed);
      pt_oe[7:0] = d1;
      dir_a = dv;
      settle();
      `CHK(port_a_oe, d1 | dv)
    end
    {cfg_has_oe_eq[7:0], pt_oe[7:0], dir_a} = '0;
    {pt_native[0][0], cfg_polarity[0], cfg_node[0]} = 3'b101;
    settle();
    `CHK(port_a_oe, 8'hFE)
    `CHK(feedback_q[0], 1'b1)
    // Both groups claim port B bit 2; group one keeps it
    wr(C2, 8'h5A);
    cfg_route_one = 8'h04;
    cfg_route_two = 8'hF8;
    settle();
    `CHK(port_b_out, 8'h5E)
    `CHK(port_b_oe, 8'h07)
    `CHK(port_c_oe, 8'hF8)
    $display("enable test done");
    dv = $random(seed);
    port_a_in = dv;
    settle();
    `CHK(input_bus_a, dv)
    chkrd(pma_pkg::OFS_IN_A, dv);
    cfg_in_mode_b = {8{2'b01}};
    // Second processor's write strobe and select form the latch term
    pt_in_enable[3:2] = 2'b11;
    d1 = $random(seed);
    port_b_in = d1;
    settle();
    pt_in_enable[3:2] = 2'b01;
    port_b_in = ~d1;
    settle();
    `CHK(input_bus_b, {d1[7:4], ~d1[3:0]})
    cfg_in_mode_c = {8{2'b10}};
    cfg_in_ale[5:4] = 2'b11;
    d2 = $random(seed);
    port_c_in = d2;
    u_host.strobe();
    port_c_in = ~d2;
    settle();
    chkrd(pma_pkg::OFS_IN_C, d2);
    $display("input cell test done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
